// file: cdc_cfg_checker_monitor.sv
// concurrent checks on the upper configuration byte registers
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module cdc_cfg_checker #(
  parameter RESULT_WORDS = 8
) (
  // clock and reset
  input wire clk, rst,
  // register bus and memory access
  input wire wr_en, rd_en, host_serial_activity, rvalid_reg, nv_req, nv_blocked, nv_granted,
  input wire [5:0] addr,
  input wire [7:0] wdata, rdata_reg,
  input wire [9:0] nv_addr,
  // result handshake
  input wire [RESULT_WORDS-1:0] result_update, result_read, result_update_ok,
  // stored controls
  input wire nv_store_enable_reg, nv_recall_enable_reg, nv_erase_reg,
  input wire hold_results_until_read_reg, alarm_a_source_reg, alarm_b_source_reg,
  input wire res_median_en_reg, cap_median_en_reg, run_switch_reg,
  input wire [3:0] pulse0_source_reg, pulse1_source_reg, memory_region_lock_reg,
  input wire [15:0] customer_tag_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // command byte write, decoded once for several checks
  wire cmd_wr = wr_en && addr == 6'h36;
  wire any_cmd = nv_store_enable_reg || nv_recall_enable_reg || nv_erase_reg;
  wire hold = hold_results_until_read_reg;

  run_readback_a: assert property (wr_en && addr == 6'h2F
    |=> run_switch_reg == $past(wdata[0])) else $error("run bit not stored");
  spare_zero_a: assert property (rd_en && addr == 6'h25 |=> rvalid_reg && rdata_reg == 8'h00)
    else $error("spare byte not zero");
  lock_low_a: assert property (nv_req && nv_addr <= 10'd703 && memory_region_lock_reg[0]
    |=> nv_blocked && !nv_granted) else $error("locked low region granted");
  lock_gap_a: assert property (nv_req && nv_addr >= 10'd1008 && nv_addr <= 10'd1021
    |=> nv_granted && !nv_blocked) else $error("unlockable gap blocked");
  tag_once_a: assert property (wr_en && addr == 6'h31 && customer_tag_reg[7:0] != 8'h00
    |=> $stable(customer_tag_reg[7:0])) else $error("nonzero tag byte overwritten");
  cmd_decode_a: assert property (cmd_wr |-> ##2 nv_store_enable_reg == ($past(wdata, 2) == 8'h2D)
    && nv_recall_enable_reg == ($past(wdata, 2) == 8'h59)
    && nv_erase_reg == ($past(wdata, 2) == 8'hB8)) else $error("command decode wrong");
  cmd_clear_a: assert property (cmd_wr ##[1:4] host_serial_activity |-> ##2 !any_cmd)
    else $error("command byte not cleared");
  hold_block_a: assert property (hold && result_update[0] && result_update_ok[0]
    && !result_read[0] |=> !hold || !result_update_ok[0]) else $error("unread word not held");
  hold_free_a: assert property (hold && result_read[0] && !result_update[0]
    |=> result_update_ok[0]) else $error("read word still held");
  pulse_src_a: assert property (wr_en && addr == 6'h27
    |-> ##2 {pulse1_source_reg, pulse0_source_reg} == $past(wdata, 2))
    else $error("pulse sources not stored");
  opt_store_a: assert property (wr_en && addr == 6'h2A |-> ##2
    {alarm_b_source_reg, alarm_a_source_reg, res_median_en_reg, cap_median_en_reg}
    == {$past(wdata[6], 2), $past(wdata[4], 2), $past(wdata[1], 2), $past(wdata[0], 2)})
    else $error("option bits not stored");

  // main scenarios reached
  erase_c: cover property (nv_erase_reg);
  blocked_c: cover property (nv_blocked);
  held_c: cover property (hold && !result_update_ok[0]);
endmodule // cdc_cfg_checker

bind cdc_upper_config_registers cdc_cfg_checker #(.RESULT_WORDS(RESULT_WORDS)) u_cdc_cfg_checker (
  .clk, .rst, .wr_en, .rd_en, .host_serial_activity, .rvalid_reg, .nv_req, .nv_blocked,
  .nv_granted, .addr, .wdata, .rdata_reg, .nv_addr, .result_update, .result_read,
  .result_update_ok, .nv_store_enable_reg, .nv_recall_enable_reg, .nv_erase_reg,
  .hold_results_until_read_reg, .alarm_a_source_reg, .alarm_b_source_reg, .res_median_en_reg,
  .cap_median_en_reg, .run_switch_reg, .pulse0_source_reg, .pulse1_source_reg,
  .memory_region_lock_reg, .customer_tag_reg);

// file: cdc_cfg_consts.vh
// constants for the upper configuration byte registers of the converter
// assumes byte-wide registers reached at 6-bit addresses from the serial port
`ifndef CDC_CFG_CONSTS_VH
`define CDC_CFG_CONSTS_VH

// register addresses
`define ADDR_SPARE_A 6'h25
`define ADDR_SETTLE 6'h26
`define ADDR_PULSE_SRC 6'h27
`define ADDR_CAP_RATIO 6'h28
`define ADDR_RES_RATIO 6'h29
`define ADDR_OPTIONS 6'h2A
`define ADDR_RUN 6'h2F
`define ADDR_LOCK 6'h30
`define ADDR_TAG_LO 6'h31
`define ADDR_TAG_HI 6'h32
`define ADDR_MEM_CMD 6'h36
`define ADDR_TRIM_LO 6'h3E
`define ADDR_TRIM_HI 6'h3F

// field positions
`define RUN_BIT 0
`define OPT_ALARM_B 6
`define OPT_POLARITY 5
`define OPT_ALARM_A 4
`define OPT_HOLD 3
`define OPT_FAST 2
`define OPT_RES_MEDIAN 1
`define OPT_CAP_MEDIAN 0
`define OPT_MASK 8'h7F
`define LOCK_MASK 8'h0F
`define LOCK_HI 3
`define PULSE1_HI 7
`define PULSE1_LO 4
`define PULSE0_HI 3
`define PULSE0_LO 0
`define PULSE_MAX 4'h7

// memory command codes
`define CMD_STORE 8'h2D
`define CMD_RECALL 8'h59
`define CMD_ERASE 8'hB8

// reset values
`define BYTE_ZERO 8'h00
`define TRIM_RESET 16'h0000

// nonvolatile region bounds, in words
`define REG0_LAST 10'h2BF
`define REG1_FIRST 10'h2C0
`define REG1_LAST 10'h33F
`define REG2_FIRST 10'h340
`define REG2_LAST 10'h3BF
`define REG3_FIRST 10'h3C0
`define REG3_LAST 10'h3EF
`define REG3B_FIRST 10'h3FE

`endif

// file: cdc_upper_config_registers.v
// upper configuration byte registers, written and read by the host serial port
// assumes the serial decoder gives one-cycle write/read strobes and an activity pulse
// Operation
// - run bit 0 cleared keeps front end and DSP idle; set lets them run.
// - each set lock bit blocks host reads and writes of its region; bit0 words 0-703.
// - lock bit1 704-831, bit2 832-959, bit3 960-1007 and 1022-1023.
// - customer tag byte writable only while zero; afterwards only erase clears it.
// - customer tag low byte at 0x31, high byte at 0x32.
// - command byte clears itself after next serial activity following its write.
// - with option bit 3 set, result words 0-7 update only after being read.
// - pulse source bits 7:4 for interface 1, 3:0 for interface 0, values 0-7.
// - option bits 4 and 6 stored as alarm source selectors for pins a and b.
// - option bits 1 and 0 stored as resistance and capacitance median enables.
// - resistance ratio selector byte stored for temperature determination.
`timescale 1ns/1ps
`include "cdc_cfg_consts.vh"

module cdc_upper_config_registers #(
  parameter RESULT_WORDS = 8,
  parameter [15:0] TRIM_INIT = `TRIM_RESET
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // register access from the serial decoder
  input wire wr_en,
  input wire rd_en,
  input wire [5:0] addr,
  input wire [7:0] wdata,
  input wire host_serial_activity,
  output reg [7:0] rdata_reg,
  output reg rvalid_reg,
  // nonvolatile access from the serial decoder
  input wire nv_req,
  input wire [9:0] nv_addr,
  output wire nv_blocked,
  output wire nv_granted,
  // result word handshake
  input wire [RESULT_WORDS-1:0] result_update,
  input wire [RESULT_WORDS-1:0] result_read,
  output wire [RESULT_WORDS-1:0] result_update_ok,
  // memory command decode
  output reg nv_store_enable_reg,
  output reg nv_recall_enable_reg,
  output reg nv_erase_reg,
  // front end and firmware controls
  output reg run_switch_reg,
  output reg hold_results_until_read_reg,
  output reg [3:0] pulse0_source_reg,
  output reg [3:0] pulse1_source_reg,
  output reg pulse0_source_valid_reg,
  output reg pulse1_source_valid_reg,
  output reg alarm_a_source_reg,
  output reg alarm_b_source_reg,
  output reg alarm_polarity_reg,
  output reg fast_mode_select_reg,
  output reg res_median_en_reg,
  output reg cap_median_en_reg,
  output reg [7:0] reference_settle_time_reg,
  output reg [7:0] cap_ratio_select_reg,
  output reg [7:0] res_ratio_select_reg,
  output reg [3:0] memory_region_lock_reg,
  output reg [15:0] customer_tag_reg,
  output reg [15:0] pump_trim_reg
);

  reg [7:0] pulse_src_reg;
  reg [7:0] options_reg;
  reg [7:0] memory_command_reg;
  reg cmd_armed_reg;
  reg [7:0] rdata_next;
  wire erase_cmd;

  // erase fires on the cycle the command byte is written
  assign erase_cmd = wr_en && (addr == `ADDR_MEM_CMD) && (wdata == `CMD_ERASE);

  // a tag byte is one-time programmable: only a zero byte takes a write
  function [7:0] otp_byte;
    input [7:0] cur;
    input [7:0] val;
    input sel;
    begin
      if (sel && (cur == `BYTE_ZERO)) begin
        otp_byte = val;
      end else begin
        otp_byte = cur;
      end
    end
  endfunction

  // plain configuration bytes; run switch keeps only bit 0
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reference_settle_time_reg <= `BYTE_ZERO;
      pulse_src_reg <= `BYTE_ZERO;
      cap_ratio_select_reg <= `BYTE_ZERO;
      res_ratio_select_reg <= `BYTE_ZERO;
      options_reg <= `BYTE_ZERO;
      run_switch_reg <= 1'b0;
      memory_region_lock_reg <= 4'h0;
      pump_trim_reg <= TRIM_INIT;
    end else if (wr_en) begin
      if (addr == `ADDR_SETTLE) begin
        reference_settle_time_reg <= wdata;
      end else if (addr == `ADDR_PULSE_SRC) begin
        pulse_src_reg <= wdata;
      end else if (addr == `ADDR_CAP_RATIO) begin
        cap_ratio_select_reg <= wdata;
      end else if (addr == `ADDR_RES_RATIO) begin
        res_ratio_select_reg <= wdata;
      end else if (addr == `ADDR_OPTIONS) begin
        options_reg <= wdata & `OPT_MASK;
      end else if (addr == `ADDR_RUN) begin
        run_switch_reg <= wdata[`RUN_BIT];
      end else if (addr == `ADDR_LOCK) begin
        memory_region_lock_reg <= wdata[`LOCK_HI:0];
      end else if (addr == `ADDR_TRIM_LO) begin
        pump_trim_reg[7:0] <= wdata;
      end else if (addr == `ADDR_TRIM_HI) begin
        pump_trim_reg[15:8] <= wdata;
      end
    end
  end

  // customer tag: write-once bytes, wiped by a complete erase
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      customer_tag_reg <= 16'h0000;
    end else if (erase_cmd) begin
      customer_tag_reg <= 16'h0000;
    end else begin
      customer_tag_reg[7:0] <= otp_byte(customer_tag_reg[7:0], wdata,
        wr_en && (addr == `ADDR_TAG_LO));
      customer_tag_reg[15:8] <= otp_byte(customer_tag_reg[15:8], wdata,
        wr_en && (addr == `ADDR_TAG_HI));
    end
  end

  // command byte arms on its write and clears at the next activity pulse;
  // activity in the write cycle itself belongs to that write, not the next one
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      memory_command_reg <= `BYTE_ZERO;
      cmd_armed_reg <= 1'b0;
    end else if (wr_en && (addr == `ADDR_MEM_CMD)) begin
      memory_command_reg <= wdata;
      cmd_armed_reg <= 1'b1;
    end else if (cmd_armed_reg && host_serial_activity) begin
      memory_command_reg <= `BYTE_ZERO;
      cmd_armed_reg <= 1'b0;
    end
  end

  // command decode, registered; unknown codes enable nothing
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      nv_store_enable_reg <= 1'b0;
      nv_recall_enable_reg <= 1'b0;
      nv_erase_reg <= 1'b0;
    end else begin
      nv_store_enable_reg <= memory_command_reg == `CMD_STORE;
      nv_recall_enable_reg <= memory_command_reg == `CMD_RECALL;
      nv_erase_reg <= memory_command_reg == `CMD_ERASE;
    end
  end

  // decoded fields, re-registered so every output leaves a flop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse0_source_reg <= 4'h0;
      pulse1_source_reg <= 4'h0;
      pulse0_source_valid_reg <= 1'b0;
      pulse1_source_valid_reg <= 1'b0;
      alarm_a_source_reg <= 1'b0;
      alarm_b_source_reg <= 1'b0;
      alarm_polarity_reg <= 1'b0;
      hold_results_until_read_reg <= 1'b0;
      fast_mode_select_reg <= 1'b0;
      res_median_en_reg <= 1'b0;
      cap_median_en_reg <= 1'b0;
    end else begin
      pulse0_source_reg <= pulse_src_reg[`PULSE0_HI:`PULSE0_LO];
      pulse1_source_reg <= pulse_src_reg[`PULSE1_HI:`PULSE1_LO];
      // codes above 7 name no result word
      pulse0_source_valid_reg <= pulse_src_reg[`PULSE0_HI:`PULSE0_LO] <= `PULSE_MAX;
      pulse1_source_valid_reg <= pulse_src_reg[`PULSE1_HI:`PULSE1_LO] <= `PULSE_MAX;
      alarm_a_source_reg <= options_reg[`OPT_ALARM_A];
      alarm_b_source_reg <= options_reg[`OPT_ALARM_B];
      alarm_polarity_reg <= options_reg[`OPT_POLARITY];
      hold_results_until_read_reg <= options_reg[`OPT_HOLD];
      fast_mode_select_reg <= options_reg[`OPT_FAST];
      res_median_en_reg <= options_reg[`OPT_RES_MEDIAN];
      cap_median_en_reg <= options_reg[`OPT_CAP_MEDIAN];
    end
  end

  // read mux; spare, internal and unmapped bytes read zero
  always @* begin
    rdata_next = `BYTE_ZERO;
    if (addr == `ADDR_SETTLE) begin
      rdata_next = reference_settle_time_reg;
    end else if (addr == `ADDR_PULSE_SRC) begin
      rdata_next = pulse_src_reg;
    end else if (addr == `ADDR_CAP_RATIO) begin
      rdata_next = cap_ratio_select_reg;
    end else if (addr == `ADDR_RES_RATIO) begin
      rdata_next = res_ratio_select_reg;
    end else if (addr == `ADDR_OPTIONS) begin
      rdata_next = options_reg;
    end else if (addr == `ADDR_RUN) begin
      rdata_next = {7'h00, run_switch_reg};
    end else if (addr == `ADDR_LOCK) begin
      rdata_next = {4'h0, memory_region_lock_reg};
    end else if (addr == `ADDR_TAG_LO) begin
      rdata_next = customer_tag_reg[7:0];
    end else if (addr == `ADDR_TAG_HI) begin
      rdata_next = customer_tag_reg[15:8];
    end else if (addr == `ADDR_MEM_CMD) begin
      rdata_next = memory_command_reg;
    end else if (addr == `ADDR_TRIM_LO) begin
      rdata_next = pump_trim_reg[7:0];
    end else if (addr == `ADDR_TRIM_HI) begin
      rdata_next = pump_trim_reg[15:8];
    end
  end

  // read data lands one cycle after the strobe and holds until the next read
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= `BYTE_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= rd_en;
      if (rd_en) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // nonvolatile region protection
  nv_lock_guard u_lock (
    .clk(clk),
    .rst(rst),
    .nv_req(nv_req),
    .nv_addr(nv_addr),
    .lock(memory_region_lock_reg),
    .nv_blocked_reg(nv_blocked),
    .nv_granted_reg(nv_granted)
  );

  // hold results until read
  result_hold_gate #(
    .WORDS(RESULT_WORDS)
  ) u_hold (
    .clk(clk),
    .rst(rst),
    .hold_en(options_reg[`OPT_HOLD]),
    .word_update(result_update),
    .word_read(result_read),
    .update_ok_reg(result_update_ok)
  );

endmodule // cdc_upper_config_registers

// file: cdc_upper_config_registers_bench.sv
// self-checking bench for the upper configuration byte registers
// assumes the host model drives the bus; result strobes come from here
`timescale 1ns/1ps
module cdc_upper_config_registers_bench;
  logic clk, rst, v;
  logic [7:0] result_update, result_read, d;
  logic [3:0] e;
  int n_mismatch, total_checks, cyc;
  int naddr [12] = '{0, 703, 704, 831, 832, 959, 960, 1007, 1008, 1021, 1022, 1023};
  logic [7:0] cmds [4] = '{8'h2D, 8'h59, 8'hB8, 8'h11};
  wire wr_en, rd_en, host_serial_activity, nv_req, rvalid_reg, nv_blocked, nv_granted;
  wire nv_store_enable_reg, nv_recall_enable_reg, nv_erase_reg, run_switch_reg;
  wire hold_results_until_read_reg, alarm_a_source_reg, alarm_b_source_reg;
  wire fast_mode_select_reg, res_median_en_reg, cap_median_en_reg;
  wire pulse0_source_valid_reg, pulse1_source_valid_reg, alarm_polarity_reg;
  wire [7:0] reference_settle_time_reg, cap_ratio_select_reg, res_ratio_select_reg;
  wire [5:0] addr;
  wire [7:0] wdata, rdata_reg, result_update_ok;
  wire [9:0] nv_addr;
  wire [3:0] pulse0_source_reg, pulse1_source_reg, memory_region_lock_reg;
  wire [15:0] customer_tag_reg, pump_trim_reg;

  cdc_upper_config_registers u_cdc_upper_config_registers (.clk, .rst, .wr_en, .rd_en, .addr,
    .wdata, .host_serial_activity, .rdata_reg, .rvalid_reg, .nv_req, .nv_addr, .nv_blocked,
    .nv_granted, .result_update, .result_read, .result_update_ok, .nv_store_enable_reg,
    .nv_recall_enable_reg, .nv_erase_reg, .run_switch_reg, .hold_results_until_read_reg,
    .pulse0_source_reg, .pulse1_source_reg, .pulse0_source_valid_reg, .pulse1_source_valid_reg,
    .alarm_a_source_reg, .alarm_b_source_reg, .alarm_polarity_reg, .fast_mode_select_reg,
    .res_median_en_reg, .cap_median_en_reg, .reference_settle_time_reg,
    .cap_ratio_select_reg, .res_ratio_select_reg, .memory_region_lock_reg,
    .customer_tag_reg, .pump_trim_reg);
  host_model u_host_model (.clk, .wr_en, .rd_en, .addr, .wdata, .rdata_reg, .rvalid_reg,
    .host_serial_activity, .nv_req, .nv_addr);

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task results;
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // read back a byte; the valid strobe must come with it
  task rchk(input [5:0] a, input [7:0] x);
    u_host_model.rd(a, d, v);
    chk({v, d}, {1'b1, x});
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  // lock mask that covers a memory word
  function automatic logic [3:0] region(input logic [9:0] a);
    if (a <= 10'd703) return 4'h1;
    if (a <= 10'd831) return 4'h2;
    if (a <= 10'd959) return 4'h4;
    if (a <= 10'd1007 || a >= 10'd1022) return 4'h8;
    return 4'h0;
  endfunction
  // cycle ceiling against a hung sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      results;
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    result_update = 8'h00;
    result_read = 8'h00;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    chk(pump_trim_reg, 16'h0000);
    u_host_model.wr(6'h2F, 8'h00);
    rchk(6'h2F, 8'h00);
    u_host_model.wr(6'h25, 8'hA5);
    rchk(6'h25, 8'h00);
    for (int i = 'h33; i <= 'h3D; i++) if (i != 'h36) u_host_model.wr(i[5:0], 8'h00);
    rchk(6'h34, 8'h00);
    u_host_model.wr(6'h30, 8'hFF);
    rchk(6'h30, 8'h0F);
    for (int b = 0; b < 4; b++) begin
      u_host_model.wr(6'h30, 8'h01 << b);
      foreach (naddr[k]) begin
        u_host_model.nv(naddr[k][9:0]);
        e = region(naddr[k][9:0]);
        chk({nv_blocked, nv_granted}, {e[b], ~e[b]});
      end
    end
    u_host_model.wr(6'h27, 8'h75);
    tick;
    chk({pulse1_source_reg, pulse0_source_reg, pulse1_source_valid_reg, pulse0_source_valid_reg},
      {8'h75, 2'b11});
    u_host_model.wr(6'h27, 8'h98);
    tick;
    chk({pulse1_source_reg, pulse0_source_reg, pulse1_source_valid_reg, pulse0_source_valid_reg},
      {8'h98, 2'b00});
    u_host_model.wr(6'h2A, 8'hF3);
    tick;
    chk({alarm_b_source_reg, alarm_a_source_reg, alarm_polarity_reg, hold_results_until_read_reg,
      fast_mode_select_reg, res_median_en_reg, cap_median_en_reg}, 7'b1110011);
    rchk(6'h2A, 8'h73);
    u_host_model.wr(6'h29, 8'h3C);
    rchk(6'h29, 8'h3C);
    chk(res_ratio_select_reg, 16'h003C);
    u_host_model.wr(6'h26, 8'h5A);
    rchk(6'h26, 8'h5A);
    chk(reference_settle_time_reg, 16'h005A);
    u_host_model.wr(6'h28, 8'hC3);
    rchk(6'h28, 8'hC3);
    chk(cap_ratio_select_reg, 16'h00C3);
    u_host_model.wr(6'h31, 8'h12);
    u_host_model.wr(6'h32, 8'h34);
    u_host_model.wr(6'h31, 8'h56);
    chk(customer_tag_reg, 16'h3412);
    rchk(6'h32, 8'h34);
    foreach (cmds[k]) begin
      u_host_model.wr(6'h36, cmds[k]);
      tick;
      chk({nv_store_enable_reg, nv_recall_enable_reg, nv_erase_reg},
        {cmds[k] == 8'h2D, cmds[k] == 8'h59, cmds[k] == 8'hB8});
      u_host_model.act;
      tick;
      chk({nv_store_enable_reg, nv_recall_enable_reg, nv_erase_reg}, 3'b000);
      rchk(6'h36, 8'h00);
    end
    chk(customer_tag_reg, 16'h0000);
    u_host_model.wr(6'h31, 8'h77);
    chk(customer_tag_reg, 16'h0077);
    // hold on: first update closes word 0 until its read, then hold off again
    u_host_model.wr(6'h2A, 8'h08);
    tick;
    tick;
    chk(hold_results_until_read_reg, 16'h0001);
    result_update = 8'h01;
    tick;
    result_update = 8'h00;
    chk(result_update_ok, 8'hFE);
    result_read = 8'h01;
    tick;
    result_read = 8'h00;
    chk(result_update_ok, 8'hFF);
    u_host_model.wr(6'h2A, 8'h00);
    tick;
    tick;
    result_update = 8'h01;
    tick;
    result_update = 8'h00;
    chk(result_update_ok, 8'hFF);
    u_host_model.wr(6'h2F, 8'hFF);
    chk(run_switch_reg, 16'h0001);
    rchk(6'h2F, 8'h01);
    results;
  end
endmodule // cdc_upper_config_registers_bench

// file: host_model.sv
// host side of the serial port: register and memory strobes
// assumes one shared clock; requests start 1 ns after a rising edge
`timescale 1ns/1ps
module host_model (
  // clock
  input wire clk,
  // register bus
  output reg wr_en,
  output reg rd_en,
  output reg [5:0] addr,
  output reg [7:0] wdata,
  input wire [7:0] rdata_reg,
  input wire rvalid_reg,
  // activity and memory access
  output reg host_serial_activity,
  output reg nv_req,
  output reg [9:0] nv_addr
);
  // idle levels at time zero
  initial begin
    {wr_en, rd_en, host_serial_activity, nv_req} = 4'h0;
    addr = 6'h00;
    wdata = 8'h00;
    nv_addr = 10'h000;
  end
  // one write strobe; trim bytes are never touched since they are per device
  task wr(input [5:0] a, input [7:0] d);
    if (a != 6'h3E && a != 6'h3F) begin
      @(posedge clk);
      #1;
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1;
      wr_en = 1'b0;
      addr = ~a;
      wdata = ~d;
    end
  endtask
  // read strobe; byte and valid taken one cycle later
  task rd(input [5:0] a, output [7:0] d, output v);
    @(posedge clk);
    #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    addr = ~a;
    d = rdata_reg;
    v = rvalid_reg;
  endtask
  // one memory word request
  task nv(input [9:0] a);
    @(posedge clk);
    #1;
    nv_req = 1'b1;
    nv_addr = a;
    @(posedge clk);
    #1;
    nv_req = 1'b0;
    nv_addr = ~a;
  endtask
  // one frame of serial activity
  task act;
    @(posedge clk);
    #1;
    host_serial_activity = 1'b1;
    @(posedge clk);
    #1;
    host_serial_activity = 1'b0;
  endtask
endmodule // host_model

// file: nv_lock_guard.v
// region lock check for nonvolatile memory accesses from the host port
// assumes the word address is stable while its request is high
`timescale 1ns/1ps
`include "cdc_cfg_consts.vh"

module nv_lock_guard (
  // clock and reset
  input wire clk,
  input wire rst,
  // access request
  input wire nv_req,
  input wire [9:0] nv_addr,
  input wire [3:0] lock,
  // verdict
  output reg nv_blocked_reg,
  output reg nv_granted_reg
);

  reg [3:0] hit;

  // which region the address lies in
  always @* begin
    hit = 4'h0;
    hit[0] = nv_addr <= `REG0_LAST;
    hit[1] = (nv_addr >= `REG1_FIRST) && (nv_addr <= `REG1_LAST);
    hit[2] = (nv_addr >= `REG2_FIRST) && (nv_addr <= `REG2_LAST);
    hit[3] = ((nv_addr >= `REG3_FIRST) && (nv_addr <= `REG3_LAST)) ||
             (nv_addr >= `REG3B_FIRST);
  end

  // verdict one cycle after the request; words 1008..1021 are never locked
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      nv_blocked_reg <= 1'b0;
      nv_granted_reg <= 1'b0;
    end else begin
      nv_blocked_reg <= nv_req && ((hit & lock) != 4'h0);
      nv_granted_reg <= nv_req && ((hit & lock) == 4'h0);
    end
  end

endmodule // nv_lock_guard

// file: result_hold_gate.v
// per result word gate that holds a new value until the old one is read
// assumes update and read strobes are one-cycle pulses
`timescale 1ns/1ps

module result_hold_gate #(
  parameter WORDS = 8
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire hold_en,
  // strobes per word
  input wire [WORDS-1:0] word_update,
  input wire [WORDS-1:0] word_read,
  // permission per word
  output reg [WORDS-1:0] update_ok_reg
);

  reg [WORDS-1:0] unread_reg;
  wire [WORDS-1:0] applied;
  wire [WORDS-1:0] unread_next;

  // an update only lands when permitted; a landing beats a same-cycle read
  assign applied = word_update & update_ok_reg;
  assign unread_next = (unread_reg & ~word_read) | applied;

  // with hold off every update is allowed
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      unread_reg <= {WORDS{1'b0}};
      update_ok_reg <= {WORDS{1'b1}};
    end else begin
      unread_reg <= unread_next;
      update_ok_reg <= hold_en ? ~unread_next : {WORDS{1'b1}};
    end
  end

endmodule // result_hold_gate
